// [bench/bel_far_side.sv]
// Model of the far side: the button contacts and the bus that sends lock commands.
// Assumes the bench calls its tasks; every output changes just after a rising clk edge.
`default_nettype none
module bel_far_side
    import bel_pkg::*;
(
    input wire logic clk,
    output logic [9:0] btn_in,
    output bel_lock_cmd_t lock_cmd,
    output logic bus_recover
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        btn_in = '0;
        lock_cmd = '0;
        bus_recover = 1'b0;
    end

    // Contact levels change only on an edge, like a debounced contact
    task automatic set_btn(input int i, input logic v);
        @(posedge clk);
        btn_in[i] <= v;
    endtask : set_btn

    task automatic lock(input int b, input logic act);
        @(posedge clk);
        lock_cmd <= '{valid: 1'b1, btn: 4'(b), active: act};
        @(posedge clk);
        lock_cmd <= '0;
    endtask : lock

    task automatic recover();
        @(posedge clk);
        bus_recover <= 1'b1;
        @(posedge clk);
        bus_recover <= 1'b0;
    endtask : recover
endmodule : bel_far_side
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench: register port tasks, an event queue model, lock and press scenarios.
// Assumes a shortened millisecond of MS cycles and the far-side model for contacts.
`default_nettype none
module tb
    import bel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MS = 10;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    bel_event_t ev;
    logic [9:0] btn_in;
    bel_lock_cmd_t lock_cmd;
    logic bus_recover;
    int n_fail = 0;
    int checks_done = 0;
    bel_event_t exp_q[$];
    logic [2:0] fn[10];
    int seed;

    always #50 clk = ~clk;

    bel_far_side far (.clk(clk), .btn_in(btn_in), .lock_cmd(lock_cmd), .bus_recover(bus_recover));
    bel_button_unit #(.MS_CYCLES(MS)) dut (.clk(clk), .nrst(nrst), .btn_in(btn_in),
        .lock_cmd(lock_cmd), .bus_recover(bus_recover), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ev(ev));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        check(name, rdata, exp);
    endtask : rd_chk

    function automatic logic [31:0] cfg(input int f, lk, inv, ret, atl, atu, m1, mode);
        bel_cfg_t c;
        c = '{event_mode: 1'(mode), nobj_m1: 3'(m1), at_unlock: bel_act_t'(atu),
            at_lock: bel_act_t'(atl), retain: 1'(ret), inv: 1'(inv), lock_en: 1'(lk),
            func: bel_func_t'(f)};
        return {18'h0, c};
    endfunction : cfg

    task automatic expect_ev(input int la, b, k, f, nobj);
        exp_q.push_back('{valid: 1'b1, lock_act: 1'(la), btn: 4'(b), kind: bel_kind_t'(k),
            func: bel_func_t'(f), nobj: 4'(nobj)});
    endtask : expect_ev

    task automatic drain(input int n);
        for (int k = 0; k < n && exp_q.size() > 0; k++)
            @(posedge clk);
        repeat (3) @(posedge clk);
        check("pending events", exp_q.size(), 0);
    endtask : drain

    // Every event the design emits is matched against the model queue
    always @(posedge clk)
    begin
        if (ev.valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("unexpected event", {17'h0, ev}, '0);
            else
                check("event", {17'h0, ev}, {17'h0, exp_q.pop_front()});
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    initial
    begin
        #(100 * 20000);
        n_fail++;
        wrap_up();
    end

    initial
    begin
        int m;
        seed = $urandom(32'h249e);
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd_chk("variant", BEL_A_CTRL, 32'h2);
        rd_chk("enables", BEL_A_BEN, 32'h3ff);
        rd_chk("lock state", BEL_A_LOCK, 32'h0);
        rd_chk("threshold", BEL_A_THR + 8'h24, 32'h320);
        rd_chk("unmapped", 8'h10, 32'h0);
        // Activation and release on every button, random object counts
        for (int i = 0; i < 10; i++)
        begin
            m = $urandom % 8;
            fn[i] = (i % 5 < 3) ? 3'(4 + i % 2) : 3'($urandom % 4);
            wr_reg(BEL_A_CFG + 8'(4 * i), cfg(fn[i], 0, 0, 0, 0, 0, m, 0));
            far.set_btn(i, 1'b1);
            expect_ev(0, i, BEL_K_CLOSE, fn[i], m + 1);
            drain(8);
            far.set_btn(i, 1'b0);
            expect_ev(0, i, BEL_K_OPEN, fn[i], m + 1);
            drain(8);
        end
        // Connected functions refused on buttons four and nine, and unknown codes
        wr_reg(BEL_A_CFG + 8'h0c, cfg(4, 0, 0, 0, 0, 0, 0, 0));
        rd_chk("func btn4", BEL_A_CFG + 8'h0c, {29'h0, fn[3]});
        wr_reg(BEL_A_CFG + 8'h20, cfg(5, 0, 0, 0, 0, 0, 0, 0));
        rd_chk("func btn9", BEL_A_CFG + 8'h20, {29'h0, fn[8]});
        wr_reg(BEL_A_CFG, cfg(6, 0, 0, 0, 0, 0, 0, 0));
        rd_chk("func code 6", BEL_A_CFG, {29'h0, fn[0]});
        // Disabled button and variant sides; stray events are caught by the monitor
        wr_reg(BEL_A_BEN, 32'h3fd);
        far.set_btn(1, 1'b1);
        far.set_btn(1, 1'b0);
        drain(8);
        wr_reg(BEL_A_BEN, 32'h3ff);
        wr_reg(BEL_A_CTRL, 32'h0);
        far.set_btn(7, 1'b1);
        far.set_btn(7, 1'b0);
        drain(8);
        wr_reg(BEL_A_CTRL, 32'h1);
        far.set_btn(2, 1'b1);
        far.set_btn(2, 1'b0);
        drain(8);
        wr_reg(BEL_A_CTRL, 32'h2);
        // Inverted lock with actions, press ignored while locked
        wr_reg(BEL_A_CFG, cfg(0, 1, 1, 0, 1, 2, 0, 0));
        far.lock(0, 1'b0);
        expect_ev(1, 0, BEL_K_CLOSE, 0, 1);
        drain(6);
        rd_chk("locked inverted", BEL_A_LOCK, 32'h1);
        far.set_btn(0, 1'b1);
        far.set_btn(0, 1'b0);
        drain(8);
        far.lock(0, 1'b1);
        expect_ev(1, 0, BEL_K_OPEN, 0, 1);
        drain(6);
        rd_chk("unlocked", BEL_A_LOCK, 32'h0);
        // Lock command to a disabled button is refused
        wr_reg(BEL_A_BEN, 32'h3fe);
        far.lock(0, 1'b0);
        rd_chk("lock unusable", BEL_A_LOCK, 32'h0);
        wr_reg(BEL_A_BEN, 32'h3ff);
        // Lock feature off ignores commands
        wr_reg(BEL_A_CFG + 8'h04, cfg(fn[1], 0, 0, 0, 0, 0, 0, 0));
        far.lock(1, 1'b1);
        rd_chk("lock off", BEL_A_LOCK, 32'h0);
        // Retention across bus recovery
        wr_reg(BEL_A_CFG, cfg(0, 1, 0, 1, 0, 0, 0, 0));
        wr_reg(BEL_A_CFG + 8'h08, cfg(fn[2], 1, 0, 0, 0, 0, 0, 0));
        far.lock(0, 1'b1);
        far.lock(2, 1'b1);
        rd_chk("two locked", BEL_A_LOCK, 32'h5);
        far.recover();
        rd_chk("after recovery", BEL_A_LOCK, 32'h1);
        far.lock(0, 1'b0);
        // Short and long press against a 2 ms threshold
        wr_reg(BEL_A_CFG + 8'h10, cfg(fn[4], 0, 0, 0, 0, 0, 0, 1));
        wr_reg(BEL_A_THR + 8'h10, 32'h2);
        far.set_btn(4, 1'b1);
        repeat (4) @(posedge clk);
        far.set_btn(4, 1'b0);
        expect_ev(0, 4, BEL_K_SHORT, fn[4], 1);
        drain(8);
        far.set_btn(4, 1'b1);
        expect_ev(0, 4, BEL_K_LONG, fn[4], 1);
        repeat (2 * MS - 3) @(posedge clk);
        check("no early long", exp_q.size(), 1);
        drain(2 * MS + 10);
        rd_chk("held", BEL_A_HELD, 32'h10);
        far.set_btn(4, 1'b0);
        drain(8);
        // Lock actions in short/long mode, four linked objects
        wr_reg(BEL_A_CFG + 8'h10, cfg(fn[4], 1, 0, 0, 2, 1, 3, 1));
        far.lock(4, 1'b1);
        expect_ev(1, 4, BEL_K_LONG, fn[4], 4);
        drain(6);
        far.lock(4, 1'b0);
        expect_ev(1, 4, BEL_K_SHORT, fn[4], 4);
        drain(6);
        wrap_up();
    end
endmodule : tb
`default_nettype wire

// [hw/bel_button_unit.sv]
// Button event and lock unit: ten buttons, register port, lock commands, event out.
// Assumes buttons and lock commands are synchronous to clk; bus_recover is a pulse.
//
// Function
// - A button works only when its enable bit is set and the variant provides its side.
// - Each button carries one function code out of six.
// - Connected dimming and connected shutter are accepted only for buttons one to three and six to eight.
// - Each button's lock can be turned off, and then lock commands do nothing to it.
// - With inversion set, lock active is taken as inactive and the reverse.
// - On bus recovery a retained lock stays, otherwise it returns to the default.
// - A lock command may fire the first or second press action, or none.
// - An unlock command may fire the first or second press action, or none.
// - Each event carries a count of linked objects, one to eight, one by default.
// - Events are either activation and release or short and long press.
// - A press is long only after being held at least the threshold in ms.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`default_nettype none
module bel_button_unit
    import bel_pkg::*;
#(
    parameter int MS_CYCLES = BEL_MS_CYC
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [9:0] btn_in,
    input wire bel_lock_cmd_t lock_cmd,
    input wire logic bus_recover,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output bel_event_t ev
);
    logic [1:0] variant;
    logic [9:0] ben;
    bel_cfg_t cfg [BEL_NBTN];
    logic [19:0] thr [BEL_NBTN];
    logic [9:0] lock, next_lock;
    logic [15:0] ms_div;
    logic tick;
    logic [31:0] next_rdata;
    bel_event_t next_ev;

    wire [9:0] usable_m;
    wire [9:0] en;
    wire [9:0] pend;
    wire [9:0] held;
    wire [9:0] ack;
    bel_kind_t kinds [BEL_NBTN];

    // Register decode
    wire [3:0] widx = addr[5:2];
    wire idx_ok = (widx < 4'(BEL_NBTN)) && (addr[1:0] == 2'h0);
    wire cfg_hit = ((addr & BEL_A_GRP) == BEL_A_CFG) && idx_ok;
    wire thr_hit = ((addr & BEL_A_GRP) == BEL_A_THR) && idx_ok;
    wire [3:0] sidx = idx_ok ? widx : 4'h0;
    wire bel_cfg_t cfg_raw = bel_cfg_t'(wdata[BEL_CFG_W-1:0]);
    wire func_ok = bel_func_ok(cfg_raw.func, int'(sidx));
    wire bel_func_t func_new = func_ok ? cfg_raw.func : cfg[sidx].func;

    // Lock command decode
    wire [3:0] lidx = (lock_cmd.btn < 4'(BEL_NBTN)) ? lock_cmd.btn : 4'h0;
    wire bel_cfg_t lcfg = cfg[lidx];
    wire lhit = lock_cmd.valid && (lock_cmd.btn < 4'(BEL_NBTN)) && usable_m[lidx]
        && lcfg.lock_en;
    wire leff = lock_cmd.active ^ lcfg.inv;
    wire bel_act_t lact = leff ? lcfg.at_lock : lcfg.at_unlock;
    wire lact_valid = lhit && (lact != BEL_A_NONE);
    wire bel_kind_t lkind = (lact == BEL_A_FIRST)
        ? (lcfg.event_mode ? BEL_K_SHORT : BEL_K_CLOSE)
        : (lcfg.event_mode ? BEL_K_LONG : BEL_K_OPEN);
    wire [9:0] retain_m;

    genvar gi;
    generate
        for (gi = 0; gi < BEL_NBTN; gi++)
        begin : g_btn
            assign usable_m[gi] = ben[gi] && bel_usable(variant, gi);
            assign en[gi] = usable_m[gi] && !lock[gi];
            assign retain_m[gi] = cfg[gi].lock_en && cfg[gi].retain;
            bel_press_timer u_timer (
                .clk(clk),
                .nrst(nrst),
                .press(btn_in[gi]),
                .enable(en[gi]),
                .mode(cfg[gi].event_mode),
                .tick(tick),
                .ack(ack[gi]),
                .thr(thr[gi]),
                .pend(pend[gi]),
                .kind(kinds[gi]),
                .held(held[gi])
            );
        end
    endgenerate

    // Lowest pending button wins; a lock action takes the slot first
    wire [9:0] pend_m = pend & en;
    logic [3:0] pick;
    always_comb
    begin
        pick = 4'h0;
        for (int i = BEL_NBTN - 1; i >= 0; i--)
            if (pend_m[i])
                pick = 4'(i);
    end
    wire pick_valid = (pend_m != 10'h000) && !lact_valid;
    assign ack = pick_valid ? (10'h001 << pick) : 10'h000;

    always_comb
    begin
        next_ev = '0;
        if (lact_valid)
        begin
            next_ev.valid = 1'b1;
            next_ev.lock_act = 1'b1;
            next_ev.btn = lidx;
            next_ev.kind = lkind;
            next_ev.func = lcfg.func;
            next_ev.nobj = {1'b0, lcfg.nobj_m1} + 4'h1;
        end
        else if (pick_valid)
        begin
            next_ev.valid = 1'b1;
            next_ev.btn = pick;
            next_ev.kind = kinds[pick];
            next_ev.func = cfg[pick].func;
            next_ev.nobj = {1'b0, cfg[pick].nobj_m1} + 4'h1;
        end
    end

    // Lock state; a command in the recovery cycle still lands
    always_comb
    begin
        next_lock = lock;
        if (bus_recover)
            next_lock = (lock & retain_m) | (~retain_m & {10{BEL_LOCK_DEFAULT}});
        if (lhit)
            next_lock[lidx] = leff;
    end

    always_comb
    begin
        next_rdata = 32'h00000000;
        if (addr == BEL_A_CTRL)
            next_rdata[1:0] = variant;
        else if (addr == BEL_A_BEN)
            next_rdata[9:0] = ben;
        else if (addr == BEL_A_LOCK)
            next_rdata[9:0] = lock;
        else if (addr == BEL_A_HELD)
            next_rdata[9:0] = held;
        else if (cfg_hit)
            next_rdata[BEL_CFG_W-1:0] = cfg[sidx];
        else if (thr_hit)
            next_rdata[BEL_THR_W-1:0] = thr[sidx];
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ms_div <= 16'h0000;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (ms_div == 16'(MS_CYCLES - 1));
            ms_div <= (ms_div == 16'(MS_CYCLES - 1)) ? 16'h0000 : ms_div + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            variant <= BEL_V_BOTH;
            ben <= BEL_RST_BEN;
            for (int i = 0; i < BEL_NBTN; i++)
            begin
                cfg[i] <= '0;
                thr[i] <= BEL_RST_THR;
            end
        end
        else if (wr)
        begin
            if (addr == BEL_A_CTRL)
                variant <= wdata[1:0];
            if (addr == BEL_A_BEN)
                ben <= wdata[9:0];
            if (cfg_hit)
                cfg[sidx] <= '{cfg_raw.event_mode, cfg_raw.nobj_m1, cfg_raw.at_unlock,
                    cfg_raw.at_lock, cfg_raw.retain, cfg_raw.inv, cfg_raw.lock_en, func_new};
            if (thr_hit)
                thr[sidx] <= wdata[BEL_THR_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lock <= {10{BEL_LOCK_DEFAULT}};
            ev <= '0;
            rdata <= 32'h00000000;
        end
        else
        begin
            lock <= next_lock;
            ev <= next_ev;
            rdata <= rd ? next_rdata : 32'h00000000;
        end
    end

    // Checking logic
    logic [9:0] usable_q, lock_q;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            usable_q <= 10'h000;
            lock_q <= 10'h000;
        end
        else
        begin
            usable_q <= usable_m;
            lock_q <= lock;
        end
    end

    logic bad_func;
    always_comb
    begin
        bad_func = 1'b0;
        for (int i = 0; i < BEL_NBTN; i++)
            if (!bel_func_ok(cfg[i].func, i))
                bad_func = 1'b1;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_lock_taken;
        lhit && !lact_valid;
    endsequence
    sequence s_lock_fires;
        lhit && lact_valid;
    endsequence
    sequence s_cfg_refused;
        wr && cfg_hit && !func_ok;
    endsequence

    a_usable_only: assert property (
        ev.valid && !ev.lock_act |-> usable_q[ev.btn])
        else $error("event from unusable button");
    a_func_legal: assert property (!bad_func)
        else $error("illegal function for button");
    a_lock_off: assert property (
        lock_cmd.valid && !lcfg.lock_en && !bus_recover |=> $stable(lock))
        else $error("lock changed while lock disabled");
    a_lock_inverted: assert property (
        s_lock_taken or s_lock_fires |=> lock[$past(lidx)] == $past(lock_cmd.active ^ lcfg.inv))
        else $error("lock state wrong after command");
    a_recover_default: assert property (
        bus_recover && !lock_cmd.valid |=> (lock & ~$past(retain_m)) == 10'h000)
        else $error("lock not defaulted on recovery");
    a_recover_keep: assert property (
        bus_recover && !lock_cmd.valid |=> (lock & $past(retain_m)) == $past(lock & retain_m))
        else $error("retained lock lost on recovery");
    a_lock_action: assert property (
        s_lock_fires ##0 leff |=> ev.valid && ev.lock_act && ev.kind == $past(lkind))
        else $error("lock action missing");
    a_unlock_action: assert property (
        lhit && !leff |=> ev.lock_act == ($past(lcfg.at_unlock) != BEL_A_NONE))
        else $error("unlock action wrong");
    a_nobj_range: assert property (
        ev.valid |-> ev.nobj >= 4'h1 && ev.nobj <= 4'h8)
        else $error("object count out of range");
    a_locked_silent: assert property (
        ev.valid && !ev.lock_act |-> !lock_q[ev.btn])
        else $error("event from locked button");
    a_event_pulse: assert property (
        ev.valid && !ev.lock_act |=> !(ev.valid && !ev.lock_act && ev.btn == $past(ev.btn)
            && ev.kind == $past(ev.kind)) || $past(ack[ev.btn]) == 1'b0)
        else $error("event repeated");
    a_cfg_refused: assert property (
        s_cfg_refused |=> cfg[$past(sidx)].func == $past(cfg[sidx].func))
        else $error("refused function was stored");
    a_unusable_lock: assert property (
        lock_cmd.valid && !usable_m[lidx] && !bus_recover |=> $stable(lock))
        else $error("lock changed on unusable button");
    a_lock_event: assert property (
        s_lock_fires |=> ev.valid && ev.lock_act && ev.btn == $past(lidx))
        else $error("lock action event on wrong button");
    a_ack_event: assert property (
        ack != 10'h000 |=> ev.valid && !ev.lock_act && ev.btn == $past(pick))
        else $error("acknowledged press not sent");
endmodule : bel_button_unit
`default_nettype wire

// [hw/bel_pkg.sv]
// Shared constants, types and helpers for the button event and lock block.
// Assumes a 10 MHz system clock and one module instance per pushbutton unit.
`default_nettype none
package bel_pkg;
    localparam int BEL_NBTN = 10;
    localparam int BEL_SIDE = 5;
    localparam int BEL_CONN_MAX = 3;
    localparam int BEL_CFG_W = 14;
    localparam int BEL_THR_W = 20;
    localparam int BEL_CLK_NS = 100;
    localparam int BEL_MS_NS = 1000000;
    localparam int BEL_MS_CYC = BEL_MS_NS / BEL_CLK_NS;
    localparam logic [7:0] BEL_A_CTRL = 8'h00;
    localparam logic [7:0] BEL_A_BEN = 8'h04;
    localparam logic [7:0] BEL_A_LOCK = 8'h08;
    localparam logic [7:0] BEL_A_HELD = 8'h0c;
    localparam logic [7:0] BEL_A_CFG = 8'h40;
    localparam logic [7:0] BEL_A_THR = 8'h80;
    localparam logic [7:0] BEL_A_GRP = 8'hc0;
    localparam logic [9:0] BEL_RST_BEN = 10'h3ff;
    localparam logic [19:0] BEL_RST_THR = 20'h00320;
    localparam logic [19:0] BEL_CNT_MAX = 20'hfffff;
    localparam logic BEL_LOCK_DEFAULT = 1'h0;

    typedef enum logic [1:0] {BEL_V_LEFT = 2'h0, BEL_V_RIGHT = 2'h1, BEL_V_BOTH = 2'h2,
        BEL_V_NONE = 2'h3} bel_variant_t;
    typedef enum logic [2:0] {BEL_F_SEND = 3'h0, BEL_F_DIM = 3'h1, BEL_F_SHUT = 3'h2,
        BEL_F_SCENE = 3'h3, BEL_F_CDIM = 3'h4, BEL_F_CSHUT = 3'h5} bel_func_t;
    typedef enum logic [1:0] {BEL_K_CLOSE = 2'h0, BEL_K_OPEN = 2'h1, BEL_K_SHORT = 2'h2,
        BEL_K_LONG = 2'h3} bel_kind_t;
    typedef enum logic [1:0] {BEL_A_NONE = 2'h0, BEL_A_FIRST = 2'h1,
        BEL_A_SECOND = 2'h2} bel_act_t;
    typedef enum logic [1:0] {BEL_S_IDLE = 2'h0, BEL_S_HELD = 2'h1,
        BEL_S_LONG = 2'h2} bel_state_t;

    typedef struct packed {
        logic event_mode;
        logic [2:0] nobj_m1;
        bel_act_t at_unlock;
        bel_act_t at_lock;
        logic retain;
        logic inv;
        logic lock_en;
        bel_func_t func;
    } bel_cfg_t;

    typedef struct packed {
        logic valid;
        logic [3:0] btn;
        logic active;
    } bel_lock_cmd_t;

    typedef struct packed {
        logic valid;
        logic lock_act;
        logic [3:0] btn;
        bel_kind_t kind;
        bel_func_t func;
        logic [3:0] nobj;
    } bel_event_t;

    function automatic logic bel_usable(input logic [1:0] v, input int idx);
        bel_usable = (idx < BEL_SIDE) ? (v == BEL_V_LEFT || v == BEL_V_BOTH)
            : (v == BEL_V_RIGHT || v == BEL_V_BOTH);
    endfunction : bel_usable

    function automatic logic bel_func_ok(input logic [2:0] f, input int idx);
        bel_func_ok = (f <= BEL_F_SCENE) ||
            ((f <= BEL_F_CSHUT) && ((idx % BEL_SIDE) < BEL_CONN_MAX));
    endfunction : bel_func_ok
endpackage : bel_pkg
`default_nettype wire

// [hw/bel_press_timer.sv]
// One button's press classifier: edges or short/long press against a threshold.
// Assumes press is synchronous and tick is a one-cycle pulse once per millisecond.
`default_nettype none
module bel_press_timer
    import bel_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic press,
    input wire logic enable,
    input wire logic mode,
    input wire logic tick,
    input wire logic ack,
    input wire logic [19:0] thr,
    output logic pend,
    output bel_kind_t kind,
    output logic held
);
    bel_state_t state, next_state;
    logic [19:0] cnt, next_cnt;
    logic set;
    bel_kind_t next_kind;

    always_comb
    begin
        next_state = state;
        next_kind = kind;
        set = 1'b0;
        next_cnt = (tick && cnt != BEL_CNT_MAX) ? cnt + 20'h00001 : cnt;
        case (state)
            BEL_S_IDLE:
            begin
                next_cnt = 20'h00000;
                if (press)
                begin
                    next_state = BEL_S_HELD;
                    set = !mode;
                    if (!mode)
                        next_kind = BEL_K_CLOSE;
                end
            end
            BEL_S_HELD:
            begin
                if (!press)
                begin
                    next_state = BEL_S_IDLE;
                    set = 1'b1;
                    next_kind = mode ? BEL_K_SHORT : BEL_K_OPEN;
                end
                else if (mode && cnt > thr)
                begin
                    next_state = BEL_S_LONG;
                    set = 1'b1;
                    next_kind = BEL_K_LONG;
                end
            end
            BEL_S_LONG:
            begin
                if (!press)
                    next_state = BEL_S_IDLE;
            end
            default: next_state = BEL_S_IDLE;
        endcase
        if (!enable)
        begin
            next_state = BEL_S_IDLE;
            set = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= BEL_S_IDLE;
            cnt <= 20'h00000;
            kind <= BEL_K_CLOSE;
            pend <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            kind <= next_kind;
            pend <= set | (pend & !ack & enable);
        end
    end

    assign held = (state != BEL_S_IDLE);

    a_long_thr: assert property (@(posedge clk) disable iff (!nrst)
        $rose(pend) && kind == BEL_K_LONG |-> $past(press && mode && cnt > thr))
        else $error("long press before threshold");
    a_short_early: assert property (@(posedge clk) disable iff (!nrst)
        $rose(pend) && kind == BEL_K_SHORT |-> $past(!press && cnt <= thr))
        else $error("short press after threshold");
    a_kind_mode: assert property (@(posedge clk) disable iff (!nrst)
        $rose(pend) |-> (kind inside {BEL_K_SHORT, BEL_K_LONG}) == $past(mode))
        else $error("event kind does not match mode");
endmodule : bel_press_timer
`default_nettype wire
